// ==== rtl/sflk_pkg.sv ====
// Constants, types and command codes for the lock, reset and ID command block
// Functional notes
// - Lock bits protect only when scheme select is 1; else complement/field decode rules.
// - Lock bits are volatile and all set to 1 after power-up or any reset.
// - Opcode 39h plus 3-byte address clears the addressed block or sector lock bit.
// - Address bits top..16 pick a 64K block, top..12 pick a 4K sector.
// - Single unlock, array lock and array unlock act only with write latch set.
// - Lock commands ending off the exact byte boundary are rejected, locks unchanged.
// - Opcode 3Dh plus 3-byte address returns the lock status byte until select rises.
// - Status 1 means protected (read only), 0 means unprotected and writable.
// - Opcode taken as 8 clocks on one line or 2 clocks on four lines.
// - Opcode 7Eh alone sets every lock bit.
// - Opcode 98h alone clears every lock bit.
// - Reset arm is discarded when any other command follows before the reset.
// - Software reset restores volatile defaults, keeping the program/erase failure flag.
// - Software reset during program or erase aborts that operation.
// - Unique ID read: command, four dummy bytes, then the fixed 128-bit identifier.
// - Parameter table read: 5Ah, three address bytes, one dummy, then table bytes.
// - Table data streams while clocks run; select rising ends it at any time.
// - Idle command only cancels a pending reset arm, nothing else.
package sflk_pkg;

    localparam int ADDR_W = 24;
    localparam int TOP_ADDR_BIT = 18;
    localparam int BLK_LSB = 16;
    localparam int SECT_LSB = 12;
    localparam int SECT_IDX_W = TOP_ADDR_BIT - SECT_LSB + 1;
    localparam int N_SECT = 1 << SECT_IDX_W;
    localparam int SECT_PER_BLK_W = BLK_LSB - SECT_LSB;
    localparam int BLK_IDX_W = SECT_IDX_W - SECT_PER_BLK_W;

    // Blocks with 4K sector granularity; the rest lock as whole 64K blocks
    localparam logic [2:0] SECT_GRAN_BLK_LO = 3'h0;
    localparam logic [2:0] SECT_GRAN_BLK_HI = 3'h7;

    localparam logic LOCK_RESET_VAL = 1'b1;

    localparam logic [7:0] OPC_SINGLE_UNLOCK = 8'h39;
    localparam logic [7:0] OPC_LOCK_STATUS = 8'h3D;
    localparam logic [7:0] OPC_ARRAY_LOCK = 8'h7E;
    localparam logic [7:0] OPC_ARRAY_UNLOCK = 8'h98;
    localparam logic [7:0] OPC_RESET_ARM = 8'h66;
    localparam logic [7:0] OPC_RESET = 8'h99;
    localparam logic [7:0] OPC_IDLE = 8'h00;
    localparam logic [7:0] OPC_UNIQUE_ID = 8'h4B;
    localparam logic [7:0] OPC_PARAM_TABLE = 8'h5A;

    // Bit counts of each phase, counted from the start of the frame
    localparam logic [8:0] OPC_END_BITS = 9'h008;
    localparam logic [8:0] ADDR_END_BITS = 9'h020;
    localparam logic [8:0] UID_DUMMY_END_BITS = 9'h028;
    localparam logic [8:0] PTAB_DUMMY_END_BITS = 9'h028;
    localparam logic [8:0] LONG_FRAME_BITS = 9'h100;

    // Arbitrary identifier value
    localparam logic [127:0] UID_VALUE = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;

    localparam logic [1:0] LOAD_DELAY = 2'h2;
    localparam logic [3:0] OE_N_SINGLE = 4'hD;
    localparam logic [3:0] OE_N_OFF = 4'hF;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic [3:0] io;
    } sflk_pins_t;

    typedef enum logic [2:0] {
        ST_OPC,
        ST_ADDR,
        ST_DUMMY,
        ST_OUT,
        ST_DONE
    } sflk_state_t;

endpackage

// ==== rtl/sflk_lock_mem.sv ====
// Volatile lock bit array with registered read ports
`timescale 1ns/1ps
module sflk_lock_mem
    import sflk_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic set_all_i,
    input wire logic clr_all_i,
    input wire logic clr_one_i,
    input wire logic clr_blk_i,
    input wire logic [SECT_IDX_W-1:0] clr_idx_i,
    input wire logic [SECT_IDX_W-1:0] rd_a_idx_i,
    input wire logic [SECT_IDX_W-1:0] rd_b_idx_i,
    output logic rd_a_o,
    output logic rd_b_o
);

    logic [N_SECT-1:0] lock_ff;
    logic [N_SECT-1:0] nxt_lock;
    wire logic [N_SECT-1:0] clr_mask;

    // Clear mask: one sector, or all sectors of one block
    for (genvar i = 0; i < N_SECT; i++) begin : g_mask
        localparam logic [SECT_IDX_W-1:0] IDX = SECT_IDX_W'(i);
        assign clr_mask[i] = clr_one_i & (clr_blk_i
            ? (IDX[SECT_IDX_W-1:SECT_PER_BLK_W] == clr_idx_i[SECT_IDX_W-1:SECT_PER_BLK_W])
            : (IDX == clr_idx_i));
    end

    assign nxt_lock = set_all_i ? {N_SECT{1'b1}}
        : clr_all_i ? {N_SECT{1'b0}}
        : (lock_ff & ~clr_mask);

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            lock_ff <= {N_SECT{LOCK_RESET_VAL}};
            rd_a_o <= LOCK_RESET_VAL;
            rd_b_o <= LOCK_RESET_VAL;
        end
        else if (ce_i)
        begin
            lock_ff <= nxt_lock;
            rd_a_o <= lock_ff[rd_a_idx_i];
            rd_b_o <= lock_ff[rd_b_idx_i];
        end
    end

endmodule

// ==== rtl/sflk_cmd.sv ====
// Serial command interpreter for lock, software reset, unique ID and table reads
`timescale 1ns/1ps
module sflk_cmd
    import sflk_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic RESET_N_I,
    input wire logic CE_I,
    input wire logic CS_N_I,
    input wire logic SCK_I,
    input wire logic [3:0] IO_I,
    output logic [3:0] IO_O,
    output logic [3:0] IO_OE_N_O,
    input wire logic QUAD_MODE_I,
    input wire logic PROTECT_SCHEME_SELECT_I,
    input wire logic BLOCK_PROTECT_HIT_I,
    input wire logic WRITE_LATCH_I,
    input wire logic PE_BUSY_I,
    input wire logic [ADDR_W-1:0] PROT_ADDR_I,
    output logic PROT_LOCKED_O,
    output logic SOFT_RESET_O,
    output logic PE_ABORT_O,
    output logic [ADDR_W-1:0] PT_ADDR_O,
    input wire logic [7:0] PT_DATA_I
);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and agreement filter

    sflk_pins_t pins_in;
    sflk_pins_t s1_ff;
    sflk_pins_t s2_ff;
    sflk_pins_t s3_ff;
    sflk_pins_t flt_ff;
    sflk_pins_t nxt_flt;
    wire logic [5:0] agree;

    assign pins_in = '{cs_n: CS_N_I, sck: SCK_I, io: IO_I};
    assign agree = ~(s2_ff ^ s3_ff);
    assign nxt_flt = (agree & s2_ff) | (~agree & flt_ff);

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            s1_ff <= '{cs_n: 1'b1, sck: 1'b0, io: 4'h0};
            s2_ff <= '{cs_n: 1'b1, sck: 1'b0, io: 4'h0};
            s3_ff <= '{cs_n: 1'b1, sck: 1'b0, io: 4'h0};
            flt_ff <= '{cs_n: 1'b1, sck: 1'b0, io: 4'h0};
        end
        else if (CE_I)
        begin
            s1_ff <= pins_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            flt_ff <= nxt_flt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame decode

    sflk_state_t state_ff;
    sflk_state_t nxt_state;
    logic [8:0] tot_ff;
    logic long_ff;
    logic [7:0] sh_in_ff;
    logic [7:0] opc_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic arm_ff;
    logic [1:0] ld_cnt_ff;
    logic [7:0] sh_out_ff;
    logic [3:0] uid_idx_ff;
    logic lock_rd_a;
    logic lock_rd_b;

    wire logic sck_rise = nxt_flt.sck & ~flt_ff.sck & ~flt_ff.cs_n & ~nxt_flt.cs_n;
    wire logic cs_rise = nxt_flt.cs_n & ~flt_ff.cs_n;
    wire logic cs_fall = ~nxt_flt.cs_n & flt_ff.cs_n;
    wire logic [8:0] step = QUAD_MODE_I ? 9'h004 : 9'h001;
    wire logic [8:0] nxt_tot = tot_ff + step;
    wire logic [7:0] nxt_sh = QUAD_MODE_I ? {sh_in_ff[3:0], nxt_flt.io}
        : {sh_in_ff[6:0], nxt_flt.io[0]};
    wire logic [ADDR_W-1:0] nxt_addr = QUAD_MODE_I ? {addr_ff[ADDR_W-5:0], nxt_flt.io}
        : {addr_ff[ADDR_W-2:0], nxt_flt.io[0]};
    wire logic opc_done = (state_ff == ST_OPC) & sck_rise & (nxt_tot == OPC_END_BITS);
    wire logic addr_done = (state_ff == ST_ADDR) & sck_rise & (nxt_tot == ADDR_END_BITS);
    wire logic [8:0] dummy_end = (opc_ff == OPC_UNIQUE_ID) ? UID_DUMMY_END_BITS
        : PTAB_DUMMY_END_BITS;
    wire logic dummy_done = (state_ff == ST_DUMMY) & sck_rise & (nxt_tot == dummy_end);
    wire logic out_rise = (state_ff == ST_OUT) & sck_rise;
    wire logic out_bound = out_rise & (nxt_tot[2:0] == 3'h0);
    wire logic ld_req = ((addr_done & (opc_ff == OPC_LOCK_STATUS)) | dummy_done
        | out_bound);
    wire logic ld_go = (ld_cnt_ff == 2'h1);

    // Next state after the opcode byte
    wire logic [7:0] opc_now = nxt_sh;
    wire logic opc_has_addr = (opc_now == OPC_SINGLE_UNLOCK) | (opc_now == OPC_LOCK_STATUS)
        | (opc_now == OPC_PARAM_TABLE);
    wire logic opc_has_dummy = (opc_now == OPC_UNIQUE_ID);

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_OPC:
            begin
                if (opc_done)
                    nxt_state = opc_has_addr ? ST_ADDR : (opc_has_dummy ? ST_DUMMY : ST_DONE);
            end
            ST_ADDR:
            begin
                if (addr_done)
                    nxt_state = (opc_ff == OPC_SINGLE_UNLOCK) ? ST_DONE
                        : (opc_ff == OPC_LOCK_STATUS) ? ST_OUT : ST_DUMMY;
            end
            ST_DUMMY:
            begin
                if (dummy_done)
                    nxt_state = ST_OUT;
            end
            ST_OUT:
            begin
                nxt_state = ST_OUT;
            end
            ST_DONE:
            begin
                nxt_state = ST_DONE;
            end
        endcase
        if (cs_rise || cs_fall)
            nxt_state = ST_OPC;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command execution at chip select rise

    wire logic opc_only = ~long_ff & (tot_ff == OPC_END_BITS);
    wire logic unlock_len = ~long_ff & (tot_ff == ADDR_END_BITS);
    wire logic do_unlock = cs_rise & (opc_ff == OPC_SINGLE_UNLOCK) & unlock_len
        & WRITE_LATCH_I;
    wire logic do_lock_all = cs_rise & (opc_ff == OPC_ARRAY_LOCK) & opc_only
        & WRITE_LATCH_I;
    wire logic do_unlock_all = cs_rise & (opc_ff == OPC_ARRAY_UNLOCK) & opc_only
        & WRITE_LATCH_I;
    wire logic soft_go = cs_rise & (opc_ff == OPC_RESET) & opc_only & arm_ff;
    wire logic arm_set = cs_rise & (opc_ff == OPC_RESET_ARM) & opc_only;
    wire logic arm_drop = (opc_done & (opc_now != OPC_RESET))
        | (cs_rise & (opc_ff == OPC_RESET));
    wire logic nxt_arm = soft_go ? 1'b0 : (arm_set ? 1'b1 : (arm_drop ? 1'b0 : arm_ff));

    // Block granularity from the top address bits
    wire logic [2:0] blk_idx = addr_ff[TOP_ADDR_BIT:BLK_LSB];
    wire logic blk_gran = (blk_idx != SECT_GRAN_BLK_LO) & (blk_idx != SECT_GRAN_BLK_HI);
    wire logic [SECT_IDX_W-1:0] sect_idx = addr_ff[TOP_ADDR_BIT:SECT_LSB];

    sflk_lock_mem u_lock_mem (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RESET_N_I),
        .ce_i(CE_I),
        .set_all_i(do_lock_all | soft_go),
        .clr_all_i(do_unlock_all),
        .clr_one_i(do_unlock),
        .clr_blk_i(blk_gran),
        .clr_idx_i(sect_idx),
        .rd_a_idx_i(sect_idx),
        .rd_b_idx_i(PROT_ADDR_I[TOP_ADDR_BIT:SECT_LSB]),
        .rd_a_o(lock_rd_a),
        .rd_b_o(lock_rd_b)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Output byte selection

    wire logic [127:0] uid_sh = UID_VALUE << {uid_idx_ff, 3'h0};
    wire logic [7:0] out_byte = (opc_ff == OPC_LOCK_STATUS) ? {7'h00, lock_rd_a}
        : (opc_ff == OPC_UNIQUE_ID) ? uid_sh[127:120]
        : PT_DATA_I;
    wire logic [7:0] shifted = QUAD_MODE_I ? {sh_out_ff[3:0], 4'h0} : {sh_out_ff[6:0], 1'b0};
    wire logic [7:0] drive_byte = ld_go ? out_byte : shifted;
    wire logic [3:0] drive_io = QUAD_MODE_I ? drive_byte[7:4]
        : {2'h0, drive_byte[7], 1'b0};

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencing registers

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            state_ff <= ST_OPC;
            tot_ff <= 9'h000;
            long_ff <= 1'b0;
            sh_in_ff <= 8'h00;
            opc_ff <= OPC_IDLE;
            addr_ff <= 24'h00_0000;
            arm_ff <= 1'b0;
        end
        else if (CE_I)
        begin
            state_ff <= nxt_state;
            arm_ff <= nxt_arm;
            if (cs_rise || cs_fall)
            begin
                tot_ff <= 9'h000;
                long_ff <= 1'b0;
            end
            else if (sck_rise)
            begin
                tot_ff <= nxt_tot;
                long_ff <= long_ff | (nxt_tot >= LONG_FRAME_BITS);
                sh_in_ff <= nxt_sh;
            end
            if (opc_done)
                opc_ff <= opc_now;
            if ((state_ff == ST_ADDR) && sck_rise)
                addr_ff <= nxt_addr;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            ld_cnt_ff <= 2'h0;
            sh_out_ff <= 8'h00;
            uid_idx_ff <= 4'h0;
            IO_O <= 4'h0;
            IO_OE_N_O <= OE_N_OFF;
            PT_ADDR_O <= 24'h00_0000;
        end
        else if (CE_I)
        begin
            if (cs_rise || cs_fall)
            begin
                ld_cnt_ff <= 2'h0;
                uid_idx_ff <= 4'h0;
                IO_OE_N_O <= OE_N_OFF;
            end
            else
            begin
                if (ld_req)
                    ld_cnt_ff <= LOAD_DELAY;
                else if (ld_cnt_ff != 2'h0)
                    ld_cnt_ff <= ld_cnt_ff - 2'h1;
                if (ld_go || (out_rise && !out_bound))
                begin
                    sh_out_ff <= drive_byte;
                    IO_O <= drive_io;
                    IO_OE_N_O <= QUAD_MODE_I ? 4'h0 : OE_N_SINGLE;
                end
                if (ld_go && (opc_ff == OPC_UNIQUE_ID))
                    uid_idx_ff <= uid_idx_ff + 4'h1;
            end
            if (addr_done)
                PT_ADDR_O <= nxt_addr;
            else if (ld_go && (opc_ff == OPC_PARAM_TABLE))
                PT_ADDR_O <= PT_ADDR_O + 24'h00_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Protection result and reset pulses

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            PROT_LOCKED_O <= LOCK_RESET_VAL;
            SOFT_RESET_O <= 1'b0;
            PE_ABORT_O <= 1'b0;
        end
        else if (CE_I)
        begin
            PROT_LOCKED_O <= PROTECT_SCHEME_SELECT_I ? lock_rd_b : BLOCK_PROTECT_HIT_I;
            SOFT_RESET_O <= soft_go;
            PE_ABORT_O <= soft_go & PE_BUSY_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RESET_N_I || !CE_I);

    sequence s_lock_cmd_end;
        cs_rise && !WRITE_LATCH_I;
    endsequence

    sequence s_status_load;
        ld_go && (opc_ff == OPC_LOCK_STATUS);
    endsequence

    a_scheme_off_bp: assert property ((!PROTECT_SCHEME_SELECT_I)[*2]
        |=> PROT_LOCKED_O == $past(BLOCK_PROTECT_HIT_I))
        else $error("protection not from block protect decode");
    a_reset_locks_all: assert property (soft_go |-> ##2 lock_rd_a)
        else $error("lock bit not set after software reset");
    a_unlock_clears: assert property (do_unlock |-> ##2 !lock_rd_a)
        else $error("addressed lock bit not cleared");
    a_latch_gates_cmd: assert property (s_lock_cmd_end
        |-> !do_unlock && !do_lock_all && !do_unlock_all)
        else $error("lock command acted without write latch");
    a_unlock_boundary: assert property (do_unlock |-> tot_ff == 9'h020)
        else $error("unlock taken off byte boundary");
    a_status_zero_bits: assert property (s_status_load
        |=> sh_out_ff[7:1] == 7'h00 && sh_out_ff[0] == $past(lock_rd_a))
        else $error("status byte malformed");
    a_array_lock_sets: assert property (do_lock_all |-> ##2 lock_rd_a)
        else $error("array lock left a bit clear");
    a_array_unlock_clr: assert property (do_unlock_all |-> ##2 !lock_rd_a)
        else $error("array unlock left a bit set");
    a_arm_discarded: assert property ((opc_done && opc_now != OPC_RESET) |=> !arm_ff)
        else $error("reset arm survived another command");
    a_abort_on_reset: assert property ((soft_go && PE_BUSY_I) |=> PE_ABORT_O
        ##1 !PE_ABORT_O)
        else $error("busy operation not aborted once");
    a_cs_ends_out: assert property (cs_rise |=> IO_OE_N_O == 4'hF)
        else $error("outputs still driven after select rise");

    a_scheme_on_lock: assert property (PROTECT_SCHEME_SELECT_I
        |=> PROT_LOCKED_O == $past(lock_rd_b))
        else $error("protection not from lock bits");
    a_soft_pulse_one: assert property (SOFT_RESET_O |=> !SOFT_RESET_O)
        else $error("software reset pulse longer than one cycle");
    a_abort_with_reset: assert property (PE_ABORT_O |-> SOFT_RESET_O)
        else $error("abort without software reset");
    a_reset_needs_arm: assert property (SOFT_RESET_O |-> $past(arm_ff))
        else $error("software reset without prior arm");
    a_idle_no_effect: assert property ((opc_done && opc_now == OPC_IDLE)
        |=> state_ff == ST_DONE)
        else $error("idle command started a transfer");
    a_single_out_oe: assert property ((ld_go && !QUAD_MODE_I && !cs_rise && !cs_fall)
        |=> IO_OE_N_O == OE_N_SINGLE)
        else $error("single line output enable wrong");
    a_quad_out_oe: assert property ((ld_go && QUAD_MODE_I && !cs_rise && !cs_fall)
        |=> IO_OE_N_O == 4'h0)
        else $error("quad output enable wrong");
    a_table_addr_load: assert property (addr_done
        |=> PT_ADDR_O == $past(nxt_addr))
        else $error("table address not loaded from command");
    a_table_addr_step: assert property ((ld_go && opc_ff == OPC_PARAM_TABLE)
        |=> PT_ADDR_O == $past(PT_ADDR_O) + 24'h00_0001)
        else $error("table address did not advance");
    a_uid_idx_step: assert property ((ld_go && opc_ff == OPC_UNIQUE_ID && !cs_rise && !cs_fall)
        |=> uid_idx_ff == $past(uid_idx_ff) + 4'h1)
        else $error("identifier byte index did not advance");

endmodule

// ==== tb/sflk_host.sv ====
// Host controller model that frames serial commands and gathers read bytes
`timescale 1ns/1ps
module sflk_host
    import sflk_pkg::*;
(
    input wire logic clk_i,
    input wire logic quad_i,
    input wire logic [3:0] io_i,
    output sflk_pins_t pins_o,
    output logic [3:0] drv_o,
    output logic rx_stb_o,
    output logic [7:0] rx_byte_o
);
    initial
    begin
        pins_o = {1'b1, 1'b0, 4'h0};
        drv_o = 4'h0;
        rx_stb_o = 1'b0;
        rx_byte_o = 8'h00;
    end
    ////////////////////////////////////////////////////////////////
    // One link clock, drive while low, sample at rise
    task automatic sck_cycle(input logic [3:0] dout, output logic [3:0] din);
        pins_o.sck = 1'b0;
        pins_o.io = dout;
        repeat (4) @(negedge clk_i);
        din = io_i;
        pins_o.sck = 1'b1;
        repeat (4) @(negedge clk_i);
    endtask
    // Opcode and payload MSB first, then read bytes
    task automatic frame(input logic [7:0] opc, input logic [31:0] pay, input int nbits,
        input int nrd);
        logic [39:0] sh;
        logic [3:0] din;
        logic [7:0] acc;
        int step;
        int b;
        sh = {opc, pay};
        step = quad_i ? 4 : 1;
        acc = 8'h00;
        @(negedge clk_i);
        pins_o.cs_n = 1'b0;
        drv_o = quad_i ? 4'hF : 4'h1;
        repeat (4) @(negedge clk_i);
        for (b = 0; b < 8 + nbits; b += step)
        begin
            sck_cycle(quad_i ? sh[39:36] : {3'h0, sh[39]}, din);
            sh = sh << step;
        end
        drv_o = 4'h0;
        for (b = 0; b < nrd * 8; b += step)
        begin
            sck_cycle(4'h0, din);
            acc = quad_i ? {acc[3:0], din} : {acc[6:0], din[1]};
            if ((b + step) % 8 == 0)
            begin
                rx_byte_o = acc;
                rx_stb_o = 1'b1;
                @(negedge clk_i);
                rx_stb_o = 1'b0;
            end
        end
        pins_o.sck = 1'b0;
        repeat (4) @(negedge clk_i);
        pins_o.cs_n = 1'b1;
        repeat (8) @(negedge clk_i);
    endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the lock, reset and identifier command block
`timescale 1ns/1ps
module testbench;
    import sflk_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic quad = 1'b0;
    logic scheme = 1'b1;
    logic bp_hit = 1'b0;
    logic wlatch = 1'b0;
    logic busy = 1'b0;
    logic [ADDR_W-1:0] paddr = 24'h00_0000;
    logic [7:0] pt_data = 8'h00;
    logic [3:0] noise = 4'h0;
    logic [3:0] io_wire;
    logic [3:0] io_o;
    logic [3:0] oe_n;
    logic [3:0] drv;
    logic locked;
    logic soft_rst;
    logic pe_abort;
    logic [ADDR_W-1:0] pt_addr;
    logic rx_stb;
    logic [7:0] rx_byte;
    sflk_pins_t pins;
    logic [7:0] exp_q[$];
    logic rst_q[$];
    logic [31:0] rng = 32'h0000_000D;
    int mismatches = 0;
    int checked = 0;

    always #12.5 clk = ~clk;
    // Released lines show a changing pattern
    assign io_wire = (~oe_n & io_o) | (oe_n & drv & pins.io) | (oe_n & ~drv & noise);
    always @(negedge clk) noise <= {noise[2:0], ~noise[3]};
    always @(negedge clk) pt_data <= pt_addr[7:0] ^ 8'hA5;

    sflk_cmd dut_u (
        .SYS_CLK_I(clk), .RESET_N_I(rst_n), .CE_I(1'b1),
        .CS_N_I(pins.cs_n), .SCK_I(pins.sck), .IO_I(io_wire),
        .IO_O(io_o), .IO_OE_N_O(oe_n), .QUAD_MODE_I(quad),
        .PROTECT_SCHEME_SELECT_I(scheme), .BLOCK_PROTECT_HIT_I(bp_hit),
        .WRITE_LATCH_I(wlatch), .PE_BUSY_I(busy), .PROT_ADDR_I(paddr),
        .PROT_LOCKED_O(locked), .SOFT_RESET_O(soft_rst), .PE_ABORT_O(pe_abort),
        .PT_ADDR_O(pt_addr), .PT_DATA_I(pt_data)
    );
    sflk_host host_u (
        .clk_i(clk), .quad_i(quad), .io_i(io_wire), .pins_o(pins),
        .drv_o(drv), .rx_stb_o(rx_stb), .rx_byte_o(rx_byte)
    );
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int nb);
        host_u.frame(op, {a, 8'h00}, nb, 0);
    endtask
    // Lock status read, two bytes noted
    task automatic status(input logic [23:0] a, input logic e);
        exp_q.push_back({7'h00, e});
        exp_q.push_back({7'h00, e});
        host_u.frame(OPC_LOCK_STATUS, {a, 8'h00}, 24, 2);
    endtask
    task automatic prot_chk(input logic [23:0] a, input logic s, input logic h, input logic e);
        paddr = a;
        scheme = s;
        bp_hit = h;
        repeat (4) @(negedge clk);
        cmp_bit(locked, e);
    endtask
    ////////////////////////////////////////////////////////////////
    // Result monitor
    always @(posedge clk)
    begin
        if (rx_stb && exp_q.size() > 0)
            cmp_byte(rx_byte, exp_q.pop_front());
        if (soft_rst || pe_abort)
        begin
            if (rst_q.size() > 0)
                cmp_byte({6'h00, soft_rst, pe_abort}, {7'h01, rst_q.pop_front()});
            else
                cmp_byte({6'h00, soft_rst, pe_abort}, 8'h00);
        end
    end
    initial
    begin
        #2_000_000;
        mismatches++;
        print_verdict();
    end
    ////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] r;
        int i;
        int j;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (8) @(negedge clk);
        for (i = 0; i < 3; i++)
        begin
            r = rnd();
            status(r[23:0], 1'b1);
            prot_chk(r[23:0], 1'b1, 1'b0, 1'b1);
        end
        cmd(OPC_SINGLE_UNLOCK, 24'h00_3000, 24);
        status(24'h00_3000, 1'b1);
        wlatch = 1'b1;
        cmd(OPC_SINGLE_UNLOCK, 24'h00_3000, 25);
        status(24'h00_3000, 1'b1);
        cmd(OPC_SINGLE_UNLOCK, 24'h00_3000, 24);
        status(24'h00_3FFF, 1'b0);
        status(24'h00_2FFF, 1'b1);
        cmd(OPC_SINGLE_UNLOCK, 24'h02_5000, 24);
        status(24'h02_0000, 1'b0);
        status(24'h03_0000, 1'b1);
        prot_chk(24'h00_3000, 1'b1, 1'b1, 1'b0);
        prot_chk(24'h00_3000, 1'b0, 1'b1, 1'b1);
        prot_chk(24'h00_2000, 1'b0, 1'b0, 1'b0);
        r = rnd();
        quad = 1'b1;
        cmd(OPC_ARRAY_UNLOCK, 24'h00_0000, 0);
        status(r[23:0], 1'b0);
        cmd(OPC_ARRAY_LOCK, 24'h00_0000, 4);
        status(r[23:0], 1'b0);
        quad = 1'b0;
        cmd(OPC_ARRAY_LOCK, 24'h00_0000, 0);
        status(r[23:0], 1'b1);
        wlatch = 1'b0;
        cmd(OPC_ARRAY_UNLOCK, 24'h00_0000, 0);
        status(r[23:0], 1'b1);
        wlatch = 1'b1;
        cmd(OPC_ARRAY_UNLOCK, 24'h00_0000, 0);
        cmd(OPC_RESET_ARM, 24'h00_0000, 0);
        cmd(OPC_IDLE, 24'h00_0000, 0);
        cmd(OPC_RESET, 24'h00_0000, 0);
        status(r[23:0], 1'b0);
        busy = 1'b1;
        rst_q.push_back(1'b1);
        cmd(OPC_RESET_ARM, 24'h00_0000, 0);
        cmd(OPC_RESET, 24'h00_0000, 0);
        busy = 1'b0;
        status(r[23:0], 1'b1);
        quad = 1'b1;
        rst_q.push_back(1'b0);
        cmd(OPC_RESET_ARM, 24'h00_0000, 0);
        cmd(OPC_RESET, 24'h00_0000, 0);
        quad = 1'b0;
        for (i = 0; i < 17; i++)
            exp_q.push_back(UID_VALUE[127 - 8 * (i % 16) -: 8]);
        host_u.frame(OPC_UNIQUE_ID, 32'h0000_0000, 32, 17);
        for (i = 0; i < 2; i++)
        begin
            quad = i[0];
            r = rnd();
            for (j = 0; j < 3; j++)
                exp_q.push_back((r[7:0] + 8'(j)) ^ 8'hA5);
            host_u.frame(OPC_PARAM_TABLE, {r[23:0], 8'h00}, 32, 3);
            cmp_byte({4'h0, oe_n}, 8'h0F);
        end
        repeat (4) @(negedge clk);
        cmp_byte(8'(exp_q.size() + rst_q.size()), 8'h00);
        print_verdict();
    end
endmodule
